//--- inc/uart_pkg.sv
package uart_pkg;
    // ********************************
    // clocking and bit timing
    // ********************************
    localparam int          CLK_HZ   = 50_000_000;
    localparam int          BAUD_DEF = 115_200;
    localparam int          OVS      = 16;
    localparam logic [15:0] DIV_RST  = 16'(CLK_HZ / (OVS * BAUD_DEF) - 1);
    localparam logic [3:0]  SUB_LAST = 4'(OVS - 1);
    localparam logic [3:0]  SUB_HALF = 4'(OVS / 2 - 1);
    localparam logic [2:0]  LEN_BASE = 3'h4;
    localparam int          NCH      = 2;

    // ********************************
    // register map, word index at byte address bits 5..2
    // ********************************
    localparam int          CH_BIT   = 6;
    localparam int          IDX_MSB  = 5;
    localparam int          IDX_LSB  = 2;
    localparam logic [3:0]  REG_DATA = 4'h0;
    localparam logic [3:0]  REG_STAT = 4'h1;
    localparam logic [3:0]  REG_CTRL = 4'h2;
    localparam logic [3:0]  REG_DIV  = 4'h3;
    localparam logic [3:0]  REG_IST  = 4'h4;
    localparam logic [3:0]  REG_IEN  = 4'h5;
    localparam logic [3:0]  REG_ICLR = 4'h6;
    localparam logic [14:0] CTRL_RST = 15'h2483;

    // interrupt status bits
    localparam int IRQ_W   = 5;
    localparam int IRQ_RXL = 0;
    localparam int IRQ_TXL = 1;
    localparam int IRQ_EOT = 2;
    localparam int IRQ_ERR = 3;
    localparam int IRQ_BRK = 4;

    // parity modes
    localparam logic [1:0] PAR_EVEN = 2'h0;
    localparam logic [1:0] PAR_ODD  = 2'h1;
    localparam logic [1:0] PAR_STK0 = 2'h2;

    typedef struct packed {
        logic [2:0] tx_trig;
        logic [2:0] rx_trig;
        logic       flow;
        logic       fifo_en;
        logic       brk;
        logic [1:0] par_mode;
        logic       par_en;
        logic       stop2;
        logic [1:0] len;
    } ctrl_t;

    typedef struct packed {
        logic cts;
        logic rx_busy;
        logic tx_busy;
        logic rx_empty;
        logic rx_full;
        logic tx_empty;
        logic tx_full;
    } stat_t;

    typedef struct packed {
        logic       brk;
        logic       perr;
        logic       ferr;
        logic [7:0] data;
    } rx_word_t;

    typedef struct packed {
        logic tx_burst;
        logic tx_single;
        logic rx_burst;
        logic rx_single;
    } dma_t;

    typedef struct packed {
        logic        acc;
        logic        we;
        logic [3:0]  idx;
        logic [31:0] wdat;
        logic [31:0] wmsk;
    } reg_req_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_START = 3'h1,
        S_DATA  = 3'h3,
        S_PAR   = 3'h2,
        S_STOP  = 3'h6
    } ser_st_t;
endpackage

//--- design/uart_pair.sv
// Operation
// - two independent channels, each with own setup, queues, interrupt, dma
// - separate transmit and receive queues of sixteen bytes each
// - queue depth selectable; one-deep mode acts as double-buffered register
// - trigger level 1/8, 1/4, 1/2, 3/4 or 7/8 of depth
// - programmable baud divider reaching three megabit per second
// - bit timing derived from system clock only
// - start bit, data, optional parity, then stop bits
// - five to eight data bits, same on both ends
// - even, odd, stick or no parity, made and checked
// - one or two stop bits sent as configured
// - line held in break on request; incoming break reported
// - sender waits on clear-to-send; receiver signals room on request-to-send
// - interrupts on trigger level and end of transmission
// - transmit and receive each drive own dma requests
// - receive single when data held, burst at trigger level
// - transmit single when space free, burst at trigger level
`timescale 1ns/1ps

// ********************************
// one serial channel
// ********************************
module uart_chan #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    // register access
    input  wire uart_pkg::reg_req_t req,
    output logic [31:0]             rdat,
    // serial pins
    input  wire logic               rxd,
    input  wire logic               cts_n,
    output logic                    txd,
    output logic                    rts_n,
    // requests
    output logic                    irq,
    output uart_pkg::dma_t          dma
);
    localparam int AW = $clog2(DEPTH);
    localparam int IW = uart_pkg::IRQ_W;

    typedef struct packed {
        uart_pkg::ctrl_t              ctrl;
        logic [15:0]                  div;
        logic [IW-1:0]                ist;
        logic [IW-1:0]                ien;
        logic [DEPTH-1:0][7:0]        tm;
        logic [AW-1:0]                twp;
        logic [AW-1:0]                trp;
        logic [AW:0]                  tcnt;
        uart_pkg::rx_word_t [DEPTH-1:0] rm;
        logic [AW-1:0]                rwp;
        logic [AW-1:0]                rrp;
        logic [AW:0]                  rcnt;
        logic [15:0]                  bcnt;
        logic                         tick;
        logic [2:0]                   rx_sy;
        logic [1:0]                   cts_sy;
        uart_pkg::ser_st_t            tst;
        logic [3:0]                   tsub;
        logic [2:0]                   tbit;
        logic                         tstop;
        logic [7:0]                   tsh;
        logic                         tpar;
        uart_pkg::ser_st_t            rxs;
        logic [3:0]                   rsub;
        logic [2:0]                   rbit;
        logic [7:0]                   rsh;
        logic                         rperr;
        logic                         busy_q;
        logic                         txd;
        logic                         rts_n;
        logic                         irq;
        uart_pkg::dma_t               dma;
    } st_t;

    st_t                q, d;
    logic               push, pop, tload, tend, rsmp, rpush, line, busy;
    logic [AW:0]        dep, ddep;
    logic [IW-1:0]      set, clr;
    logic [7:0]         ral;
    uart_pkg::rx_word_t rw;
    uart_pkg::stat_t    stat;

    // ********************************
    // helpers
    // ********************************
    function automatic logic [AW:0] dep_of(input logic en);
        return en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    endfunction

    function automatic logic [AW:0] trig(input logic [2:0] s, input logic en);
        logic [AW:0] t;
        case (s)
            3'h0:    t = (AW+1)'(DEPTH / 8);
            3'h1:    t = (AW+1)'(DEPTH / 4);
            3'h2:    t = (AW+1)'(DEPTH / 2);
            3'h3:    t = (AW+1)'(DEPTH * 3 / 4);
            default: t = (AW+1)'(DEPTH * 7 / 8);
        endcase
        return en ? t : (AW+1)'(1);
    endfunction

    // index of the last data bit
    function automatic logic [2:0] lastbit(input logic [1:0] len);
        return 3'({1'b0, len} + uart_pkg::LEN_BASE);
    endfunction

    // parity over the used data bits
    function automatic logic par(input logic [7:0] v, input logic [1:0] len,
                                 input logic [1:0] mode);
        logic x;
        x = ^(v & 8'(8'hff >> (2'h3 - len)));
        case (mode)
            uart_pkg::PAR_EVEN: par = x;
            uart_pkg::PAR_ODD:  par = ~x;
            uart_pkg::PAR_STK0: par = 1'b0;
            default:            par = 1'b1;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input uart_pkg::reg_req_t r);
        return (old & ~r.wmsk) | (r.wdat & r.wmsk);
    endfunction

    // ********************************
    // next state
    // ********************************
    always_comb begin
        d    = q;
        dep  = dep_of(q.ctrl.fifo_en);
        clr  = '0;
        set  = '0;
        // divider gives sixteen ticks per bit
        // taken from the system clock alone
        d.tick = (q.bcnt == 16'h0000);
        d.bcnt = d.tick ? q.div : q.bcnt - 16'h0001;
        // pins pass two flops; third rx flop only remembers the last level
        d.rx_sy  = {q.rx_sy[1:0], rxd};
        d.cts_sy = {q.cts_sy[0], cts_n};
        line     = q.rx_sy[1];

        // register side effects; a write to a full queue is dropped
        pop  = req.acc & ~req.we & (req.idx == uart_pkg::REG_DATA) & (q.rcnt != '0);
        push = req.acc & req.we & (req.idx == uart_pkg::REG_DATA) & req.wmsk[0]
             & (q.tcnt < dep);
        if (req.acc && req.we) begin
            if (req.idx == uart_pkg::REG_CTRL) begin
                d.ctrl = uart_pkg::ctrl_t'(15'(merge(32'(q.ctrl), req)));
            end else if (req.idx == uart_pkg::REG_DIV) begin
                d.div = 16'(merge(32'(q.div), req));
            end else if (req.idx == uart_pkg::REG_IEN) begin
                d.ien = IW'(merge(32'(q.ien), req));
            end else if (req.idx == uart_pkg::REG_ICLR) begin
                clr = IW'(req.wdat & req.wmsk);
            end
        end
        if (push) begin
            d.tm[q.twp] = req.wdat[7:0];
            d.twp       = q.twp + 1'b1;
        end

        // no new character while the partner holds clear-to-send off
        tload = (q.tst == uart_pkg::S_IDLE) & (q.tcnt != '0) & ~q.ctrl.brk
              & ~(q.ctrl.flow & q.cts_sy[1]);
        tend  = q.tick & (q.tsub == uart_pkg::SUB_LAST);
        if (q.tst != uart_pkg::S_IDLE && q.tick) begin
            d.tsub = q.tsub + 4'h1;
        end
        case (q.tst)
            uart_pkg::S_IDLE: if (tload) begin
                d.tst   = uart_pkg::S_START;
                d.tsub  = '0;
                d.tsh   = q.tm[q.trp];
                d.trp   = q.trp + 1'b1;
                d.tstop = 1'b0;
                d.tpar  = par(q.tm[q.trp], q.ctrl.len, q.ctrl.par_mode);
            end
            uart_pkg::S_START: if (tend) begin
                d.tst  = uart_pkg::S_DATA;
                d.tbit = '0;
            end
            uart_pkg::S_DATA: if (tend) begin
                d.tsh  = q.tsh >> 1;
                d.tbit = q.tbit + 3'h1;
                if (q.tbit == lastbit(q.ctrl.len)) begin
                    d.tst = q.ctrl.par_en ? uart_pkg::S_PAR : uart_pkg::S_STOP;
                end
            end
            uart_pkg::S_PAR: if (tend) begin
                d.tst = uart_pkg::S_STOP;
            end
            uart_pkg::S_STOP: if (tend) begin
                d.tstop = 1'b1;
                if (!q.ctrl.stop2 || q.tstop) begin
                    d.tst = uart_pkg::S_IDLE;
                end
            end
            default: d.tst = uart_pkg::S_IDLE;
        endcase
        case (d.tst)
            uart_pkg::S_START: d.txd = 1'b0;
            uart_pkg::S_DATA:  d.txd = d.tsh[0];
            uart_pkg::S_PAR:   d.txd = d.tpar;
            default:           d.txd = 1'b1;
        endcase
        // break overrides the line, even mid-character
        if (d.ctrl.brk) begin
            d.txd = 1'b0;
        end
        if (push && !tload) begin
            d.tcnt = q.tcnt + (AW+1)'(1);
        end else if (tload && !push) begin
            d.tcnt = q.tcnt - (AW+1)'(1);
        end

        // sample at bit centre on the sixteenth tick
        rsmp  = q.tick & (q.rsub == uart_pkg::SUB_LAST);
        rpush = 1'b0;
        if (q.rxs != uart_pkg::S_IDLE && q.tick) begin
            d.rsub = q.rsub + 4'h1;
        end
        // short characters land in the top bits; align them down
        ral     = 8'(q.rsh >> (2'h3 - q.ctrl.len));
        rw.data = ral;
        rw.ferr = ~line;
        rw.perr = q.rperr;
        // break is all-zero data with the stop bit low
        rw.brk  = (ral == 8'h00) & ~line;
        case (q.rxs)
            uart_pkg::S_IDLE: if (q.rx_sy[2] && !line) begin
                d.rxs   = uart_pkg::S_START;
                d.rsub  = '0;
                d.rperr = 1'b0;
            end
            // glitch shorter than half a bit is dropped
            uart_pkg::S_START: if (q.tick && q.rsub == uart_pkg::SUB_HALF) begin
                d.rsub = '0;
                d.rbit = '0;
                d.rxs  = line ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
            end
            uart_pkg::S_DATA: if (rsmp) begin
                d.rsh  = {line, q.rsh[7:1]};
                d.rbit = q.rbit + 3'h1;
                if (q.rbit == lastbit(q.ctrl.len)) begin
                    d.rxs = q.ctrl.par_en ? uart_pkg::S_PAR : uart_pkg::S_STOP;
                end
            end
            uart_pkg::S_PAR: if (rsmp) begin
                d.rperr = line ^ par(ral, q.ctrl.len, q.ctrl.par_mode);
                d.rxs   = uart_pkg::S_STOP;
            end
            uart_pkg::S_STOP: if (rsmp) begin
                rpush = (q.rcnt < dep);
                d.rxs = uart_pkg::S_IDLE;
            end
            default: d.rxs = uart_pkg::S_IDLE;
        endcase
        // depth limit holds the receive queue to one entry when off
        if (rpush) begin
            d.rm[q.rwp] = rw;
            d.rwp       = q.rwp + 1'b1;
        end
        if (pop) begin
            d.rrp = q.rrp + 1'b1;
        end
        if (rpush && !pop) begin
            d.rcnt = q.rcnt + (AW+1)'(1);
        end else if (pop && !rpush) begin
            d.rcnt = q.rcnt - (AW+1)'(1);
        end

        ddep           = dep_of(d.ctrl.fifo_en);
        busy           = (d.tst != uart_pkg::S_IDLE) | (d.tcnt != '0);
        d.busy_q       = busy;
        set[uart_pkg::IRQ_RXL] = d.rcnt >= trig(d.ctrl.rx_trig, d.ctrl.fifo_en);
        set[uart_pkg::IRQ_TXL] = (ddep - d.tcnt) >= trig(d.ctrl.tx_trig, d.ctrl.fifo_en);
        set[uart_pkg::IRQ_EOT] = q.busy_q & ~busy;
        set[uart_pkg::IRQ_ERR] = rpush & (rw.ferr | rw.perr);
        set[uart_pkg::IRQ_BRK] = rpush & rw.brk;
        // a set in the same cycle as its clear wins
        d.ist = (q.ist & ~clr) | set;
        d.irq = |(d.ist & d.ien);
        d.dma.rx_single = (d.rcnt != '0);
        d.dma.rx_burst  = set[uart_pkg::IRQ_RXL];
        d.dma.tx_single = (d.tcnt < ddep);
        d.dma.tx_burst  = set[uart_pkg::IRQ_TXL];
        // request-to-send low while the receive queue has room
        d.rts_n = d.ctrl.flow & (d.rcnt >= ddep);
    end

    // state register; line idle high so no false start after reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            q               <= '0;
            q.ctrl          <= uart_pkg::CTRL_RST;
            q.div           <= uart_pkg::DIV_RST;
            q.rx_sy         <= '1;
            q.cts_sy        <= '1;
            q.txd           <= 1'b1;
            q.dma.tx_single <= 1'b1;
            q.dma.tx_burst  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // status word and read decode
    always_comb begin
        stat.cts      = ~q.cts_sy[1];
        stat.rx_busy  = (q.rxs != uart_pkg::S_IDLE);
        stat.tx_busy  = q.busy_q;
        stat.rx_empty = (q.rcnt == '0);
        stat.rx_full  = (q.rcnt >= dep_of(q.ctrl.fifo_en));
        stat.tx_empty = (q.tcnt == '0);
        stat.tx_full  = (q.tcnt >= dep_of(q.ctrl.fifo_en));
        rdat          = '0;
        if (req.idx == uart_pkg::REG_DATA) begin
            rdat = stat.rx_empty ? '0 : 32'(q.rm[q.rrp]);
        end else if (req.idx == uart_pkg::REG_STAT) begin
            rdat = 32'(stat);
        end else if (req.idx == uart_pkg::REG_CTRL) begin
            rdat = 32'(q.ctrl);
        end else if (req.idx == uart_pkg::REG_DIV) begin
            rdat = 32'(q.div);
        end else if (req.idx == uart_pkg::REG_IST) begin
            rdat = 32'(q.ist);
        end else if (req.idx == uart_pkg::REG_IEN) begin
            rdat = 32'(q.ien);
        end
    end

    assign txd   = q.txd;
    assign rts_n = q.rts_n;
    assign irq   = q.irq;
    assign dma   = q.dma;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_stop_first;
        q.tst == uart_pkg::S_STOP && tend && !q.tstop && q.ctrl.stop2;
    endsequence
    sequence s_stop_hold;
        (q.tst == uart_pkg::S_STOP && txd)[*8];
    endsequence

    AST_START_LOW: assert property (q.tst == uart_pkg::S_START |-> !txd)
        else $error("start bit not low");
    AST_BRK_LOW: assert property (q.ctrl.brk |-> !txd)
        else $error("break not holding line low");
    AST_CTS_WAIT: assert property (
        q.tst == uart_pkg::S_IDLE && q.ctrl.flow && q.cts_sy[1]
        |=> q.tst == uart_pkg::S_IDLE)
        else $error("character started while clear-to-send off");
    AST_TWO_STOP: assert property (s_stop_first ##0 !q.ctrl.brk |=> s_stop_hold)
        else $error("second stop bit missing");
    AST_ONE_DEEP: assert property (
        !q.ctrl.fifo_en && q.rcnt != '0 && !pop |=> q.rcnt == $past(q.rcnt))
        else $error("one-deep receive queue grew");
    AST_RX_SINGLE: assert property (dma.rx_single == (q.rcnt != '0))
        else $error("receive single request wrong");
    AST_TX_SINGLE: assert property (
        dma.tx_single == (q.tcnt < dep_of(q.ctrl.fifo_en)))
        else $error("transmit single request wrong");
    AST_IRQ_GATE: assert property (irq == |(q.ist & q.ien))
        else $error("interrupt output disagrees with status");
    AST_EOT: assert property (q.busy_q && !busy |=> q.ist[uart_pkg::IRQ_EOT])
        else $error("end of transmission not flagged");
    AST_FERR: assert property (
        q.rxs == uart_pkg::S_STOP && rsmp && !line && q.rcnt < dep
        |=> q.ist[uart_pkg::IRQ_ERR] && q.rcnt != '0)
        else $error("framing error not reported");
    AST_TX_MAX: assert property (q.tcnt <= (AW+1)'(DEPTH))
        else $error("transmit queue over depth");
endmodule

// ********************************
// two channels behind one wishbone slave
// ********************************
module uart_pair #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_b,
    // wishbone slave
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [7:0]                           wb_adr_i,
    input  wire logic [3:0]                           wb_sel_i,
    input  wire logic [31:0]                          wb_dat_i,
    output logic [31:0]                               wb_dat_o,
    output logic                                      wb_ack_o,
    // serial pins, one bit per channel
    input  wire logic [uart_pkg::NCH-1:0]             rxd,
    input  wire logic [uart_pkg::NCH-1:0]             cts_n,
    output logic [uart_pkg::NCH-1:0]                  txd,
    output logic [uart_pkg::NCH-1:0]                  rts_n,
    // interrupts and dma requests
    output logic [uart_pkg::NCH-1:0]                  irq,
    output uart_pkg::dma_t [uart_pkg::NCH-1:0]        dma
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_st_t;

    wb_st_t                                  q, d;
    logic                                    go, mapped, ch;
    logic [3:0]                              idx;
    uart_pkg::reg_req_t [uart_pkg::NCH-1:0]  reqs;
    logic [uart_pkg::NCH-1:0][31:0]          rdats;

    function automatic logic [31:0] bmask(input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    // decode; ack one cycle after the request, unmapped answers zero
    always_comb begin
        go     = wb_cyc_i & wb_stb_i & ~q.ack;
        idx    = wb_adr_i[uart_pkg::IDX_MSB:uart_pkg::IDX_LSB];
        ch     = wb_adr_i[uart_pkg::CH_BIT];
        mapped = (idx <= uart_pkg::REG_ICLR) & ~wb_adr_i[7];
        for (int i = 0; i < uart_pkg::NCH; i++) begin
            reqs[i].acc  = go & mapped & (ch == 1'(i));
            reqs[i].we   = wb_we_i;
            reqs[i].idx  = idx;
            reqs[i].wdat = wb_dat_i;
            reqs[i].wmsk = bmask(wb_sel_i);
        end
        d.ack = go;
        d.dat = (go && !wb_we_i && mapped) ? rdats[ch] : '0;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;

    for (genvar i = 0; i < uart_pkg::NCH; i++) begin : g_ch
        uart_chan #(.DEPTH(DEPTH)) u_chan (
            .sys_clk (sys_clk),
            .rst_b   (rst_b),
            .req     (reqs[i]),
            .rdat    (rdats[i]),
            .rxd     (rxd[i]),
            .cts_n   (cts_n[i]),
            .txd     (txd[i]),
            .rts_n   (rts_n[i]),
            .irq     (irq[i]),
            .dma     (dma[i])
        );
    end
endmodule

//--- dv/uart_far_end.sv
`timescale 1ns/1ps
// ****************
// far end: 8N1 at 16 clocks a bit
// ****************
module uart_far_end (
    // clock
    input  wire logic  sys_clk,
    // line
    input  wire logic  rx,
    output logic       tx = 1'b1,
    // byte seen, stop bit on top
    output logic       got = 1'b0,
    output logic [8:0] seen
);
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            tx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (16) @(posedge sys_clk);
        end
    endtask
    // sample near bit centre; stop bit kept so the bench sees it
    always begin
        @(negedge rx);
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (16) @(posedge sys_clk);
            seen[i] = rx;
        end
        got <= 1'b1;
        @(posedge sys_clk);
        got <= 1'b0;
    end
endmodule

//--- dv/tb_uart_pair.sv
`timescale 1ns/1ps
// ****************
// bench: channel 0 to far end, channel 1 looped
// ****************
module tb_uart_pair;
    logic        sys_clk = 1'b0, rst_b = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, exp_rd[$];
    logic        wb_ack_o, far_tx, got;
    logic [1:0]  txd, rts_n, irq, cts_n = 2'h0;
    logic [8:0]  seen, exp_ser[$];
    logic [15:0] seed = 16'hA782;
    int          err_total = 0, n_compared = 0;
    uart_pkg::dma_t [1:0] dma;
    // clear-to-send driven per channel, low is active
    uart_pair u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd({txd[1], far_tx}), .cts_n(cts_n),
        .txd(txd), .rts_n(rts_n), .irq(irq), .dma(dma));
    uart_far_end u_far (.sys_clk(sys_clk), .rx(txd[0]), .tx(far_tx), .got(got), .seen(seen));
    always #10 sys_clk = ~sys_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string what, input logic [31:0] got_v, input logic [31:0] e);
        n_compared++;
        if (got_v !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, got_v);
        end
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1) @(posedge sys_clk);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask
    // results taken off the queues as they appear
    always @(posedge sys_clk) begin
        if (wb_ack_o && !wb_we) check("rdat", wb_dat_o, exp_rd.pop_front());
        if (got) check("txd0", 32'(seen), 32'(exp_ser.pop_front()));
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        check("dma irq rts", 32'({dma, irq, rts_n}), 32'h0000_0CC0);
        rd(8'h08, 32'h0000_2483);
        rd(8'h0C, 32'h0000_001A);
        rd(8'h3C, 32'h0000_0000);
        wb(1'b1, 8'h0C, 32'h0000_0000);
        wb(1'b1, 8'h4C, 32'h0000_0000);
        wb(1'b1, 8'h14, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            exp_ser.push_back({1'b1, seed[7:0]});
            wb(1'b1, 8'h00, {24'h0, seed[7:0]});
        end
        for (int i = 0; i < 3000 && exp_ser.size() != 0; i++) @(posedge sys_clk);
        repeat (40) @(posedge sys_clk);
        check("irq0", 32'(irq[0]), 32'h1);
        rd(8'h10, 32'h0000_0006);
        wb(1'b1, 8'h18, 32'h0000_0004);
        repeat (2) @(posedge sys_clk);
        check("irq0", 32'(irq[0]), 32'h0);
        u_far.send(8'hA5);
        repeat (4) @(posedge sys_clk);
        check("dma0", 32'(dma[0]), 32'h0000_000D);
        rd(8'h00, 32'h0000_00A5);
        // clear-to-send off holds a byte back; one-deep queue drops a second byte
        cts_n <= 2'h1;
        wb(1'b1, 8'h08, 32'h0000_2503);
        seed = lfsr(seed);
        exp_ser.push_back({1'b1, seed[7:0]});
        wb(1'b1, 8'h00, {24'h0, seed[7:0]});
        repeat (100) @(posedge sys_clk);
        rd(8'h04, 32'h0000_0019);
        cts_n <= 2'h0;
        repeat (200) @(posedge sys_clk);
        u_far.send(8'h5A);
        check("rts_n", 32'(rts_n), 32'h1);
        wb(1'b1, 8'h08, 32'h0000_2403);
        u_far.send(8'hC3);
        rd(8'h00, 32'h0000_005A);
        rd(8'h00, 32'h0000_0000);
        // every length, parity mode and stop count through the loop
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wb(1'b1, 8'h48, 32'h0000_2488 | i | (i[0] << 2) | (i << 4));
            wb(1'b1, 8'h40, {24'h0, seed[7:0]});
            repeat (260) @(posedge sys_clk);
            rd(8'h40, {24'h0, seed[7:0] & (8'hFF >> (3 - i))});
        end
        wb(1'b1, 8'h48, 32'h0000_24C3);
        repeat (300) @(posedge sys_clk);
        wb(1'b1, 8'h48, 32'h0000_2483);
        repeat (40) @(posedge sys_clk);
        rd(8'h40, 32'h0000_0500);
        check("ser left", 32'(exp_ser.size()), 32'h0);
        print_verdict();
    end
    // cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
endmodule
